// >>> hw/flash_id_cfg.svh
// Constants for the wake and identity command block
`ifndef FLASH_ID_CFG_SVH
`define FLASH_ID_CFG_SVH
// Opcodes
`define OP_WAKE 8'hab
`define OP_PAIR_ID 8'h90
`define OP_STD_ID 8'h9f
`define OP_SLEEP 8'hb9
// Address selecting device byte first in the paired read
`define PAIR_SWAP_ADDR 24'h000001
// Dummy bytes after the wake opcode before the device code
`define WAKE_DUMMY_BYTES 3
// Clock period in ps (200 MHz)
`define MCLK_PERIOD_PS 5000
// Wake and sleep-entry intervals in ns (arbitrary plain defaults)
`define SHORT_WAKE_NS 3000
`define LONG_WAKE_NS 5000
`define SLEEP_ENTRY_NS 3000
// Power-up write delay, min 1 ms, max 10 ms, in ns
`define PUW_MAX_NS 10000000
// Cycle counts, times rounded up; power-up delay taken from its maximum
`define SHORT_WAKE_CYC ((`SHORT_WAKE_NS * 1000 + `MCLK_PERIOD_PS - 1) / `MCLK_PERIOD_PS)
`define LONG_WAKE_CYC ((`LONG_WAKE_NS * 1000 + `MCLK_PERIOD_PS - 1) / `MCLK_PERIOD_PS)
`define SLEEP_ENTRY_CYC ((`SLEEP_ENTRY_NS * 1000 + `MCLK_PERIOD_PS - 1) / `MCLK_PERIOD_PS)
`define PUW_CYC ((64'd`PUW_MAX_NS * 64'd1000 + 64'd4999) / 64'd`MCLK_PERIOD_PS)
`endif

// >>> hw/flash_id_pkg.sv
// Types for the wake and identity command block
package flash_id_pkg;
  // Command phase, Gray coded along opcode -> address -> output
  typedef enum logic [2:0] {
    PH_OPCODE = 3'b000,
    PH_ADDR = 3'b001,
    PH_SHIFT = 3'b011,
    PH_IGNORE = 3'b010
  } phase_e;
  // Power state
  typedef enum logic [1:0] {
    PW_AWAKE = 2'b00,
    PW_ENTERING = 2'b01,
    PW_SLEEP = 2'b11,
    PW_WAKING = 2'b10
  } power_e;
  // Which identity answer is being shifted
  typedef enum logic [1:0] {
    ID_DEV = 2'b00,
    ID_PAIR = 2'b01,
    ID_STD = 2'b11
  } idsel_e;
endpackage

// >>> hw/flash_wake_id.sv
// SPI slave command logic for wake, sleep entry and identity reads
`timescale 1ns/100ps
`include "flash_id_cfg.svh"

// Operation
// - Asleep, ignore every opcode except wake
// - After short wake interval, accept commands
// - Wake plus three dummies outputs device code
// - Device code repeats until select rises
// - Wake-with-code from sleep uses long interval
// - Wake opcode ignored while write in progress
// - Opcode 90h, address 0: manufacturer, device
// - Address 1 swaps: device then manufacturer
// - Opcode 9Fh: manufacturer, type, capacity
// - Refuse writes during power-up write delay
// - Write-in-progress high throughout self-timed cycle
// - Opcode B9h then select rise enters sleep
// - Sleep request rejected during write cycle
module flash_wake_id #(
  parameter logic [7:0] MANUF_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h3c, // Arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h40, // Arbitrary value
  parameter logic [7:0] CAPACITY = 8'h15, // Arbitrary value
  parameter logic [31:0] PUW_CYCLES = 32'(`PUW_CYC),
  parameter logic [15:0] SHORT_WAKE_CYCLES = 16'(`SHORT_WAKE_CYC),
  parameter logic [15:0] LONG_WAKE_CYCLES = 16'(`LONG_WAKE_CYC),
  parameter logic [15:0] SLEEP_ENTRY_CYCLES = 16'(`SLEEP_ENTRY_CYC)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // SPI pins
  input wire logic chipSelectN,
  input wire logic serialClock,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOutEn,
  // Links to the rest of the device
  input wire logic writeInProgress,
  output logic writeInProgressFlag,
  output logic deepSleep,
  output logic writeAllowed,
  output logic cmdAccepted
);
  import flash_id_pkg::*;
  // Every pin is sampled by mclk, so a pin edge is seen three to four
  // cycles late; the serial clock must stay well below a quarter of mclk.
  // Data out moves about four cycles after a falling serial clock edge,
  // leaving the host most of the low half of the period to settle it.
  // Limitation: only the identity answers are driven; array reads live elsewhere.

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [2:0] csSync; // Three-stage synchronisers
    logic [2:0] sckSync;
    logic [2:0] sdiSync;
    logic csN; // Filtered levels
    logic sck;
    phase_e phase;
    power_e power;
    idsel_e idSel;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [5:0] bitCnt; // Bits received in the current phase
    logic [4:0] outBit; // Position in the answer stream
    logic [15:0] waitCnt; // Wake and sleep-entry timer
    logic [31:0] puwCnt; // Power-up write delay timer
    logic wakeDone; // Wake opcode completed this frame
    logic fromSleep; // Frame began while not awake
    logic dataOut;
    logic dataOutEn;
    logic wipFlag;
    logic puwDone;
    logic accepted;
    logic asleep; // Registered copy of the sleep state for the port
  } state_s;

  state_s cur;
  state_s next_cur;

  // Answer byte for the current stream position
  // Bits 4:3 of the position pick the byte, bits 2:0 the bit within it;
  // the wrap points live with the counters in the next-state logic
  function automatic logic [7:0] answerByte(input idsel_e sel, input logic [4:0] pos,
                                            input logic swap);
    logic [1:0] idx;
    idx = pos[4:3];
    answerByte = DEVICE_ID;
    case (sel)
      ID_DEV: answerByte = DEVICE_ID; // Repeats forever
      ID_PAIR: begin
        if (idx[0] ^ swap) begin
          answerByte = DEVICE_ID;
        end else begin
          answerByte = MANUF_ID;
        end
      end
      ID_STD: begin
        case (idx)
          2'd0: answerByte = MANUF_ID;
          2'd1: answerByte = MEM_TYPE;
          2'd2: answerByte = CAPACITY;
          default: answerByte = MANUF_ID;
        endcase
      end
      default: answerByte = DEVICE_ID;
    endcase
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************
  // All decisions read the registered copy; raw pins only enter the synchronisers,
  // which keeps metastable samples out of the frame logic
  always_comb begin
    logic [7:0] shifted;
    logic csRise;
    logic csFall;
    logic sckRise;
    logic sckFall;
    logic [7:0] outByte;
    shifted = '0;
    outByte = '0;
    // Edge flags start clear, then follow the filtered levels below
    csRise = 1'b0;
    csFall = 1'b0;
    sckRise = 1'b0;
    sckFall = 1'b0;
    next_cur = cur;
    next_cur.accepted = 1'b0;
    // Synchronise pins; a change counts when stages two and three agree
    next_cur.csSync = {cur.csSync[1:0], chipSelectN};
    next_cur.sckSync = {cur.sckSync[1:0], serialClock};
    next_cur.sdiSync = {cur.sdiSync[1:0], serialDataIn};
    if (cur.csSync[2] == cur.csSync[1]) begin
      next_cur.csN = cur.csSync[2];
    end
    if (cur.sckSync[2] == cur.sckSync[1]) begin
      next_cur.sck = cur.sckSync[2];
    end
    csRise = next_cur.csN && !cur.csN;
    csFall = !next_cur.csN && cur.csN;
    sckRise = next_cur.sck && !cur.sck && !cur.csN;
    sckFall = !next_cur.sck && cur.sck && !cur.csN;
    // Write-in-progress mirrors the self-timed cycle
    next_cur.wipFlag = writeInProgress;
    // Power-up write delay counts down from its maximum
    if (cur.puwCnt != '0) begin
      next_cur.puwCnt = cur.puwCnt - 32'd1;
    end else begin
      next_cur.puwDone = 1'b1;
    end
    // Power timers
    // One shared counter serves entry and wake; they never overlap, since
    // frames arriving while it runs are ignored
    if (cur.waitCnt != '0) begin
      next_cur.waitCnt = cur.waitCnt - 16'd1;
    end
    case (cur.power)
      PW_ENTERING: begin
        if (cur.waitCnt == '0) begin
          next_cur.power = PW_SLEEP;
        end
      end
      PW_WAKING: begin
        if (cur.waitCnt == '0) begin
          next_cur.power = PW_AWAKE;
        end
      end
      default: ;
    endcase
    // Frame start
    // Counters restart on every select fall, so a cut frame leaves no
    // half-shifted opcode behind for the next one
    if (csFall) begin
      next_cur.phase = PH_OPCODE;
      next_cur.bitCnt = '0;
      next_cur.wakeDone = 1'b0;
      next_cur.fromSleep = (cur.power != PW_AWAKE);
      // Busy timers: the host must keep select high, so ignore the frame
      if (cur.power == PW_ENTERING || cur.power == PW_WAKING) begin
        next_cur.phase = PH_IGNORE;
      end
    end
    // Sample on rising serial clock
    // Data in is taken from the third stage, aligned with the clock sample
    // that shows the rise
    if (sckRise) begin
      case (cur.phase)
        PH_OPCODE: begin
          shifted = {cur.opcode[6:0], cur.sdiSync[2]};
          next_cur.opcode = shifted;
          next_cur.bitCnt = cur.bitCnt + 6'd1;
          if (cur.bitCnt == 6'd7) begin
            next_cur.bitCnt = '0;
            next_cur.outBit = '0;
            if (cur.power == PW_SLEEP && shifted != `OP_WAKE) begin
              next_cur.phase = PH_IGNORE;
            end else if (shifted == `OP_WAKE && cur.wipFlag) begin
              next_cur.phase = PH_IGNORE;
            end else if (shifted == `OP_WAKE) begin
              next_cur.wakeDone = 1'b1;
              next_cur.idSel = ID_DEV;
              next_cur.phase = PH_ADDR; // Three dummy bytes
              next_cur.accepted = 1'b1;
            end else if (shifted == `OP_PAIR_ID) begin
              next_cur.idSel = ID_PAIR;
              next_cur.phase = PH_ADDR;
              next_cur.accepted = 1'b1;
            end else if (shifted == `OP_STD_ID) begin
              next_cur.idSel = ID_STD;
              next_cur.phase = PH_SHIFT; // No address
              next_cur.accepted = 1'b1;
            end else begin
              next_cur.phase = PH_IGNORE; // Other opcodes belong elsewhere
              next_cur.accepted = (shifted == `OP_SLEEP);
            end
          end
        end
        PH_ADDR: begin
          next_cur.addr = {cur.addr[22:0], cur.sdiSync[2]};
          next_cur.bitCnt = cur.bitCnt + 6'd1;
          if (cur.bitCnt == 6'(`WAKE_DUMMY_BYTES * 8 - 1)) begin
            next_cur.phase = PH_SHIFT;
            // Odd addresses other than one fall back to normal order
            next_cur.addr = {cur.addr[22:0], cur.sdiSync[2]};
          end
        end
        PH_IGNORE: begin
          // Bits past an ignored opcode are counted so that a sleep opcode
          // with trailing bits does not take effect
          if (cur.bitCnt != 6'h3f) begin
            next_cur.bitCnt = cur.bitCnt + 6'd1;
          end
        end
        default: ;
      endcase
    end
    // Drive on falling serial clock, MSB first
    if (sckFall && cur.phase == PH_SHIFT) begin
      outByte = answerByte(cur.idSel, cur.outBit, cur.addr == `PAIR_SWAP_ADDR);
      next_cur.dataOut = outByte[3'd7 - cur.outBit[2:0]];
      next_cur.dataOutEn = 1'b1;
      if (cur.idSel == ID_DEV) begin
        next_cur.outBit = {2'b00, cur.outBit[2:0] + 3'd1};
      end else if (cur.idSel == ID_PAIR) begin
        next_cur.outBit = {1'b0, cur.outBit[3:0] + 4'd1};
      end else begin
        next_cur.outBit = (cur.outBit == 5'd23) ? 5'd0 : cur.outBit + 5'd1;
      end
    end
    // Frame end
    // Sleep entry needs select to rise with no bit after the opcode;
    // a busy cycle blocks it so the self-timed work runs to the end
    if (csRise) begin
      next_cur.dataOutEn = 1'b0;
      next_cur.phase = PH_IGNORE;
      if (cur.wakeDone && cur.fromSleep && cur.power == PW_SLEEP) begin
        next_cur.power = PW_WAKING;
        // Longer interval once the code was read plain wake
        next_cur.waitCnt = (cur.phase == PH_SHIFT) ? LONG_WAKE_CYCLES : SHORT_WAKE_CYCLES;
      end else if (cur.power == PW_AWAKE && cur.phase == PH_IGNORE &&
                   cur.bitCnt == '0 && cur.opcode == `OP_SLEEP && !cur.wipFlag) begin
        next_cur.power = PW_ENTERING;
        next_cur.waitCnt = SLEEP_ENTRY_CYCLES;
      end
    end
    if (cur.csN || cur.phase != PH_SHIFT) begin
      next_cur.dataOutEn = 1'b0;
    end
    // Port copy of the sleep state, so the output comes from a flop
    next_cur.asleep = (next_cur.power == PW_SLEEP);
  end

  // ****************************************
  // Registers
  // ****************************************
  // Reset parks select high in its synchroniser, so no false select fall
  // and hence no phantom frame follows the release of reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      cur <= '0;
      cur.csSync <= 3'b111;
      cur.csN <= 1'b1;
      cur.phase <= PH_IGNORE;
      cur.power <= PW_AWAKE; // Always powers up in standby
      cur.puwCnt <= PUW_CYCLES;
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************
  // Outputs straight from flip-flops
  // ****************************************
  // Plain wires from the state register; no decode sits between flop and pin
  assign serialDataOut = cur.dataOut;
  assign serialDataOutEn = cur.dataOutEn;
  assign writeInProgressFlag = cur.wipFlag;
  assign deepSleep = cur.asleep;
  assign writeAllowed = cur.puwDone;
  assign cmdAccepted = cur.accepted;
endmodule // flash_wake_id

// >>> tb/flash_wake_id_chk.sv
// Port checker for the wake and identity command block
`timescale 1ns/100ps
module flash_wake_id_chk #(
  parameter logic [31:0] PUW_CYCLES = 32'h64
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Pins and links watched
  input wire logic chipSelectN,
  input wire logic serialClock,
  input wire logic serialDataOut,
  input wire logic serialDataOutEn,
  input wire logic writeInProgress,
  input wire logic writeInProgressFlag,
  input wire logic deepSleep,
  input wire logic writeAllowed,
  input wire logic cmdAccepted
);
  logic [31:0] upCount; // Cycles since release, saturating so it never wraps
  // Count time since reset release
  always_ff @(posedge mclk) begin
    if (rst) begin
      upCount <= 32'h0;
    end else if (upCount != 32'hffffffff) begin
      upCount <= upCount + 32'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property ($fell(rst) |-> !serialDataOutEn && !deepSleep && !cmdAccepted)
    else $error("outputs not quiet after reset");
  a_puw_hold: assert property (upCount + 32'h3 < PUW_CYCLES |-> !writeAllowed)
    else $error("writes allowed too early");
  a_puw_done: assert property (upCount > PUW_CYCLES + 32'h3 |-> writeAllowed)
    else $error("writes still refused");
  a_wip_flag: assert property (writeInProgress[*2] |-> writeInProgressFlag)
    else $error("busy flag low in cycle");
  a_idle_release: assert property (chipSelectN[*8] |-> !serialDataOutEn)
    else $error("data out driven while deselected");
  a_wake_not_busy: assert property ($fell(deepSleep) |-> !writeInProgressFlag)
    else $error("woke during busy cycle");
  a_sleep_not_busy: assert property ($rose(deepSleep) |-> !writeInProgressFlag)
    else $error("slept during busy cycle");
  a_shift_on_fall: assert property (serialDataOutEn && $past(serialDataOutEn)
    && $changed(serialDataOut) |-> !serialClock)
    else $error("data out changed with clock high");
endmodule // flash_wake_id_chk

bind flash_wake_id flash_wake_id_chk #(.PUW_CYCLES(PUW_CYCLES)) uChk (.mclk(mclk), .rst(rst),
  .chipSelectN(chipSelectN), .serialClock(serialClock), .serialDataOut(serialDataOut),
  .serialDataOutEn(serialDataOutEn), .writeInProgress(writeInProgress),
  .writeInProgressFlag(writeInProgressFlag), .deepSleep(deepSleep),
  .writeAllowed(writeAllowed), .cmdAccepted(cmdAccepted));

// >>> tb/spi_host_model.sv
// SPI host model driving frames onto the device pins
`timescale 1ns/100ps
module spi_host_model (
  // Pins toward the device
  output logic chipSelectN,
  output logic serialClock,
  output logic serialDataIn,
  input wire logic serialDataOut
);
  // Idle: deselected, clock standing still low
  initial begin
    chipSelectN = 1'b1;
    serialClock = 1'b0;
    serialDataIn = 1'b0;
  end
  // Send nTx bits MSB first, then clock nRx answer bits in on rises
  task automatic frame(input logic [31:0] tx, input int nTx, input int nRx,
      output logic [47:0] rx);
    rx = '0;
    chipSelectN = 1'b0;
    #32;
    for (int i = 0; i < nTx + nRx; i++) begin
      // Past the command the line toggles so no stale bit looks valid
      serialDataIn = (i < nTx) ? tx[31 - i] : ~serialDataIn;
      #32 serialClock = 1'b1;
      if (i >= nTx) rx = {rx[46:0], serialDataOut};
      #32 serialClock = 1'b0;
    end
    #8 chipSelectN = 1'b1; // Select rises right after the last bit
    serialDataIn = ~serialDataIn;
    // Stay deselected long enough for the device to see the rise
    #64;
  endtask
endmodule // spi_host_model

// >>> tb/tb_flash_wake_id.sv
// Self-checking bench for the wake and identity command block
`timescale 1ns/100ps
module tb_flash_wake_id;
  localparam int PUW = 100; // Shortened power-up write delay
  localparam int WAKE = 20; // Shortened wake and entry intervals
  localparam logic [7:0] MAN = 8'h5a; // Arbitrary value
  localparam logic [7:0] DEV = 8'h3c; // Arbitrary value
  localparam logic [7:0] TYP = 8'h40; // Arbitrary value
  localparam logic [7:0] CAP = 8'h15; // Arbitrary value
  logic mclk, rst, chipSelectN, serialClock, serialDataIn, serialDataOut, serialDataOutEn;
  logic writeInProgress, writeInProgressFlag, deepSleep, writeAllowed, cmdAccepted;
  logic enSeen; // Data out was enabled since last cleared
  logic [47:0] rx;
  // Line as the host sees it: a released output shows the inverse of its last bit
  logic sdoLine;
  assign sdoLine = serialDataOutEn ? serialDataOut : ~serialDataOut;
  int failures, total_checks, accCount;
  flash_wake_id #(.MANUF_ID(MAN), .DEVICE_ID(DEV), .MEM_TYPE(TYP), .CAPACITY(CAP),
    .PUW_CYCLES(32'(PUW)), .SHORT_WAKE_CYCLES(16'(WAKE)), .LONG_WAKE_CYCLES(16'(2 * WAKE)),
    .SLEEP_ENTRY_CYCLES(16'(WAKE))) dut (.mclk(mclk), .rst(rst), .chipSelectN(chipSelectN),
    .serialClock(serialClock), .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
    .serialDataOutEn(serialDataOutEn), .writeInProgress(writeInProgress),
    .writeInProgressFlag(writeInProgressFlag), .deepSleep(deepSleep),
    .writeAllowed(writeAllowed), .cmdAccepted(cmdAccepted));
  spi_host_model host (.chipSelectN(chipSelectN), .serialClock(serialClock),
    .serialDataIn(serialDataIn), .serialDataOut(sdoLine));
  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Watch accepted opcodes and output enable
  always @(posedge mclk) begin
    if (cmdAccepted === 1'b1) accCount++;
    if (serialDataOutEn === 1'b1) enSeen = 1'b1;
  end
  task automatic chk(string what, logic [47:0] exp, logic [47:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Writes refused until the power-up delay has run
  task automatic t_power_up;
    chk("writeAllowed", 48'h0, {47'h0, writeAllowed});
    idle(PUW + 10);
    chk("writeAllowed", 48'h1, {47'h0, writeAllowed});
  endtask
  // All three identity reads, each repeating
  task automatic t_ids;
    accCount = 0;
    host.frame({8'h9f, 24'h0}, 8, 48, rx);
    chk("std id", {MAN, TYP, CAP, MAN, TYP, CAP}, rx);
    host.frame({8'h90, 24'h0}, 32, 32, rx);
    chk("pair id", {16'h0, MAN, DEV, MAN, DEV}, rx);
    host.frame({8'h90, 24'h1}, 32, 32, rx);
    chk("pair swap", {16'h0, DEV, MAN, DEV, MAN}, rx);
    host.frame({8'hab, 24'h0}, 32, 16, rx);
    chk("dev code", {32'h0, DEV, DEV}, rx);
    chk("accepted awake", 48'h4, 48'(accCount));
  endtask
  // Sleep, ignored opcode, wake only, then a normal read
  task automatic t_sleep;
    host.frame({8'hb9, 24'h0}, 16, 0, rx);
    idle(WAKE + 10);
    chk("deepSleep late rise", 48'h0, {47'h0, deepSleep});
    host.frame({8'hb9, 24'h0}, 8, 0, rx);
    idle(WAKE + 10);
    chk("deepSleep", 48'h1, {47'h0, deepSleep});
    accCount = 0;
    host.frame({8'h9f, 24'h0}, 8, 24, rx);
    idle(10);
    chk("accepted asleep", 48'h0, 48'(accCount));
    chk("deepSleep", 48'h1, {47'h0, deepSleep});
    host.frame({8'hab, 24'h0}, 8, 0, rx);
    idle(WAKE + 10);
    chk("deepSleep", 48'h0, {47'h0, deepSleep});
    host.frame({8'h9f, 24'h0}, 8, 24, rx);
    chk("std id awake", {24'h0, MAN, TYP, CAP}, rx);
  endtask
  // Leave sleep with the code read and the longer interval
  task automatic t_sleep_code;
    host.frame({8'hb9, 24'h0}, 8, 0, rx);
    idle(WAKE + 10);
    host.frame({8'hab, 24'h0}, 32, 8, rx);
    chk("code from sleep", {40'h0, DEV}, rx);
    idle(2 * WAKE + 10); // Host keeps select high for the long interval
    chk("deepSleep", 48'h0, {47'h0, deepSleep});
    host.frame({8'h9f, 24'h0}, 8, 8, rx);
    chk("man after long wake", {40'h0, MAN}, rx);
  endtask
  // Busy cycle: sleep request and wake code both ignored
  task automatic t_busy;
    writeInProgress = 1'b1;
    idle(3);
    chk("busy flag", 48'h1, {47'h0, writeInProgressFlag});
    host.frame({8'hb9, 24'h0}, 8, 0, rx);
    idle(WAKE + 10);
    chk("deepSleep", 48'h0, {47'h0, deepSleep});
    enSeen = 1'b0;
    host.frame({8'hab, 24'h0}, 32, 16, rx);
    chk("output enabled", 48'h0, {47'h0, enSeen});
    idle(1);
    writeInProgress = 1'b0;
    idle(3);
    chk("busy flag", 48'h0, {47'h0, writeInProgressFlag});
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    writeInProgress = 1'b0;
    accCount = 0;
    enSeen = 1'b0;
    idle(2);
    rst = 1'b0;
    idle(1);
    t_power_up();
    t_ids();
    t_sleep();
    t_sleep_code();
    t_busy();
    end_of_test();
  end
  // Hang guard, well beyond the expected run
  initial begin
    #200000;
    failures++;
    end_of_test();
  end
endmodule // tb_flash_wake_id
